// ==== verilog/nds_pkg.sv ====
package nds_pkg;

  // ----------------------------------------------------------------------
  // sizing
  // ----------------------------------------------------------------------
  localparam int unsigned N_SAME = 4;  // nodes of the observer's kind
  localparam int unsigned N_OPP  = 3;  // nodes of the opposite kind
  localparam int unsigned SEL_W  = 3;  // index width for either kind

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [N_SAME-1:0]       RST_SAME = '0;  // nothing accused/convicted
  localparam logic [N_OPP-1:0]        RST_OPP  = '0;
  localparam logic [N_SAME*N_OPP-1:0] RST_SUSP = '0;  // no suspicions

  // ----------------------------------------------------------------------
  // major modes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    NDS_MODE_IDLE,
    NDS_MODE_PRESERVE,
    NDS_MODE_JOIN,
    NDS_MODE_DETECT,
    NDS_MODE_INIT,
    NDS_MODE_SELFTEST
  } nds_mode_t;

endpackage

// ==== verilog/nds_diag_state.sv ====
`timescale 1ns/10ps
module nds_diag_state (
  // clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 rstn,
  // mode control, same-clock strobes
  input  wire nds_pkg::nds_mode_t                   mode,
  input  wire logic                                 mode_entry,
  input  wire logic                                 cd_start,
  input  wire logic                                 cd_end,
  input  wire logic                                 interval_end,
  // conviction update from collective diagnosis
  input  wire logic [nds_pkg::N_SAME-1:0]           conv_same_in,
  input  wire logic [nds_pkg::N_OPP-1:0]            conv_opp_in,
  // direct blame, one pulse per error
  input  wire logic [nds_pkg::N_SAME-1:0]           blame_same,
  input  wire logic [nds_pkg::N_OPP-1:0]            blame_opp,
  // relayed-path error report
  input  wire logic                                 relay_err,
  input  wire logic [nds_pkg::SEL_W-1:0]            relay_src,
  input  wire logic [nds_pkg::SEL_W-1:0]            relay_mid,
  input  wire logic                                 relay_pinned,
  // state outputs
  output logic [nds_pkg::N_SAME-1:0]                acc_same_eff,
  output logic [nds_pkg::N_OPP-1:0]                 acc_opp_eff,
  output logic [nds_pkg::N_SAME-1:0]                acc_same_submit,
  output logic [nds_pkg::N_OPP-1:0]                 acc_opp_submit,
  output logic [nds_pkg::N_SAME-1:0]                conv_same,
  output logic [nds_pkg::N_OPP-1:0]                 conv_opp,
  output logic [nds_pkg::N_SAME-1:0]                trust_same,
  output logic [nds_pkg::N_OPP-1:0]                 trust_opp,
  output logic [nds_pkg::N_SAME*nds_pkg::N_OPP-1:0] susp,
  output logic                                      cd_active
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [nds_pkg::N_SAME-1:0]           acc_same_r, acc_same_nxt;   // current interval
  logic [nds_pkg::N_OPP-1:0]            acc_opp_r,  acc_opp_nxt;
  logic [nds_pkg::N_SAME-1:0]           sav_same_r, sav_same_nxt;   // saved copy
  logic [nds_pkg::N_OPP-1:0]            sav_opp_r,  sav_opp_nxt;
  logic [nds_pkg::N_SAME-1:0]           conv_same_r, conv_same_nxt; // convictions
  logic [nds_pkg::N_OPP-1:0]            conv_opp_r,  conv_opp_nxt;
  logic [nds_pkg::N_SAME*nds_pkg::N_OPP-1:0] susp_r, susp_nxt;      // matrix
  logic                                 cd_r, cd_nxt;                // diagnosis running
  logic [nds_pkg::N_SAME-1:0]           eff_same_r, eff_same_nxt;
  logic [nds_pkg::N_OPP-1:0]            eff_opp_r,  eff_opp_nxt;
  logic [nds_pkg::N_SAME-1:0]           sub_same_r, sub_same_nxt;
  logic [nds_pkg::N_OPP-1:0]            sub_opp_r,  sub_opp_nxt;
  logic [nds_pkg::N_SAME-1:0]           tr_same_r,  tr_same_nxt;
  logic [nds_pkg::N_OPP-1:0]            tr_opp_r,   tr_opp_nxt;

  // ----------------------------------------------------------------------
  // gathering gate and suspicion hit map
  // ----------------------------------------------------------------------
  logic                                      gather;   // findings may be recorded
  logic                                      clr_all;  // detect/init entry
  logic [nds_pkg::N_SAME*nds_pkg::N_OPP-1:0] susp_hit; // one-hot suspicion cell

  // self-test records nothing about other nodes
  assign gather  = (mode != nds_pkg::NDS_MODE_SELFTEST) &&
                   (mode != nds_pkg::NDS_MODE_IDLE);
  // detect and init start from a clean slate
  assign clr_all = mode_entry && ((mode == nds_pkg::NDS_MODE_DETECT) ||
                                  (mode == nds_pkg::NDS_MODE_INIT));

  // one cell per same-kind source and opposite-kind relay pair
  genvar gi;
  generate
    for (gi = 0; gi < nds_pkg::N_SAME*nds_pkg::N_OPP; gi++) begin : g_cell
      // a single unpinned relayed error is enough to mark the cell
      assign susp_hit[gi] = gather && relay_err && !relay_pinned &&
                            (relay_src == nds_pkg::SEL_W'(gi / nds_pkg::N_OPP)) &&
                            (relay_mid == nds_pkg::SEL_W'(gi % nds_pkg::N_OPP));
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    acc_same_nxt  = acc_same_r;
    acc_opp_nxt   = acc_opp_r;
    sav_same_nxt  = sav_same_r;
    sav_opp_nxt   = sav_opp_r;
    conv_same_nxt = conv_same_r;
    conv_opp_nxt  = conv_opp_r;
    susp_nxt      = susp_r;
    cd_nxt        = cd_r;
    sub_same_nxt  = sub_same_r;
    sub_opp_nxt   = sub_opp_r;
    // interval clears; blame and suspicions raised the same cycle survive
    if (clr_all) begin
      acc_same_nxt  = nds_pkg::RST_SAME;
      acc_opp_nxt   = nds_pkg::RST_OPP;
      sav_same_nxt  = nds_pkg::RST_SAME;
      sav_opp_nxt   = nds_pkg::RST_OPP;
      conv_same_nxt = nds_pkg::RST_SAME;
      conv_opp_nxt  = nds_pkg::RST_OPP;
      susp_nxt      = nds_pkg::RST_SUSP;
      cd_nxt        = 1'b0;
    end else if (cd_start && gather) begin
      // save the finished interval and submit it
      sav_same_nxt  = acc_same_r;
      sav_opp_nxt   = acc_opp_r;
      sub_same_nxt  = acc_same_r;
      sub_opp_nxt   = acc_opp_r;
      acc_same_nxt  = nds_pkg::RST_SAME;
      acc_opp_nxt   = nds_pkg::RST_OPP;
      susp_nxt      = nds_pkg::RST_SUSP;
      cd_nxt        = 1'b1;
    end else if (interval_end) begin
      // local interval over outside of diagnosis start
      acc_same_nxt  = nds_pkg::RST_SAME;
      acc_opp_nxt   = nds_pkg::RST_OPP;
      susp_nxt      = nds_pkg::RST_SUSP;
    end
    // diagnosis end: load convictions, forget saved copy
    if (cd_end && cd_r && !clr_all) begin
      conv_same_nxt = conv_same_in;
      conv_opp_nxt  = conv_opp_in;
      sav_same_nxt  = nds_pkg::RST_SAME;
      sav_opp_nxt   = nds_pkg::RST_OPP;
      cd_nxt        = 1'b0;
    end
    // direct blame: while gathering (preserve, join, detect, init) errors with others are blamed on them
    if (gather) begin
      acc_same_nxt = acc_same_nxt | blame_same;
      acc_opp_nxt  = acc_opp_nxt | blame_opp;
    end
    // relayed ambiguity only touches the matrix, never accusations
    susp_nxt = susp_nxt | susp_hit;
  end

  // effective accusations and trust, from the next state
  always_comb begin
    eff_same_nxt = acc_same_nxt | (cd_nxt ? sav_same_nxt : nds_pkg::RST_SAME);
    eff_opp_nxt  = acc_opp_nxt | (cd_nxt ? sav_opp_nxt : nds_pkg::RST_OPP);
    tr_same_nxt  = ~(eff_same_nxt | conv_same_nxt);
    tr_opp_nxt   = ~(eff_opp_nxt | conv_opp_nxt);
  end

  // ----------------------------------------------------------------------
  // registers; join/preserve share the same path
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc_same_r  <= nds_pkg::RST_SAME;
      acc_opp_r   <= nds_pkg::RST_OPP;
      sav_same_r  <= nds_pkg::RST_SAME;
      sav_opp_r   <= nds_pkg::RST_OPP;
      conv_same_r <= nds_pkg::RST_SAME;
      conv_opp_r  <= nds_pkg::RST_OPP;
      susp_r      <= nds_pkg::RST_SUSP;
      cd_r        <= 1'b0;
      eff_same_r  <= nds_pkg::RST_SAME;
      eff_opp_r   <= nds_pkg::RST_OPP;
      sub_same_r  <= nds_pkg::RST_SAME;
      sub_opp_r   <= nds_pkg::RST_OPP;
      tr_same_r   <= ~nds_pkg::RST_SAME;
      tr_opp_r    <= ~nds_pkg::RST_OPP;
    end else begin
      acc_same_r  <= acc_same_nxt;
      acc_opp_r   <= acc_opp_nxt;
      sav_same_r  <= sav_same_nxt;
      sav_opp_r   <= sav_opp_nxt;
      conv_same_r <= conv_same_nxt;
      conv_opp_r  <= conv_opp_nxt;
      susp_r      <= susp_nxt;
      cd_r        <= cd_nxt;
      eff_same_r  <= eff_same_nxt;
      eff_opp_r   <= eff_opp_nxt;
      sub_same_r  <= sub_same_nxt;
      sub_opp_r   <= sub_opp_nxt;
      tr_same_r   <= tr_same_nxt;
      tr_opp_r    <= tr_opp_nxt;
    end
  end

  // outputs straight from flops
  assign acc_same_eff    = eff_same_r;
  assign acc_opp_eff     = eff_opp_r;
  assign acc_same_submit = sub_same_r;
  assign acc_opp_submit  = sub_opp_r;
  assign conv_same       = conv_same_r;
  assign conv_opp        = conv_opp_r;
  assign trust_same      = tr_same_r;
  assign trust_opp       = tr_opp_r;
  assign susp            = susp_r;
  assign cd_active       = cd_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // convictions move only on an accepted diagnosis end or a wipe
  AST_CONV_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(cd_end && cd_r) && !clr_all |=> $stable(conv_same_r) && $stable(conv_opp_r))
    else $error("convictions changed outside update");
  // accepted end loads the agreed convictions of both kinds
  AST_CONV_LOAD: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_end && cd_r && !clr_all |=> conv_same_r == $past(conv_same_in))
    else $error("conviction update not loaded");
  AST_CONV_LOAD_OPP: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_end && cd_r && !clr_all |=> conv_opp_r == $past(conv_opp_in))
    else $error("opposite conviction update not loaded");
  // accepted start hands the finished interval to the far side
  AST_SUBMIT: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_start && gather && !clr_all |=>
      sub_same_r == $past(acc_same_r) && sub_opp_r == $past(acc_opp_r))
    else $error("accusations not submitted at start");
  // submitted copy stands until the next accepted start
  AST_SUBMIT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(cd_start && gather) |=> $stable(sub_same_r) && $stable(sub_opp_r))
    else $error("submitted accusations changed without start");
  // start keeps a copy of the finished interval and runs diagnosis
  AST_START_SAVE: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_start && gather && !clr_all && !cd_end |=> sav_same_r == $past(acc_same_r) && cd_r)
    else $error("accusations not saved at start");
  // start leaves only the blame raised in the same cycle
  AST_START_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_start && gather && !clr_all |=>
      ((acc_same_r & ~$past(blame_same)) == '0) && ((acc_opp_r & ~$past(blame_opp)) == '0))
    else $error("accusations not cleared at start");
  // start restarts the matrix, keeping same-cycle suspicions
  AST_START_SUSP: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_start && gather && !clr_all |=> susp_r == $past(susp_hit))
    else $error("suspicions not cleared at start");
  // effective accusation during diagnosis is saved or new, both kinds
  AST_EFF_OR: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_r |=> eff_same_r == (acc_same_r | sav_same_r))
    else $error("effective accusation not merged");
  AST_EFF_OR_OPP: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_r |=> eff_opp_r == (acc_opp_r | sav_opp_r))
    else $error("effective opposite accusation not merged");
  // outside diagnosis only the current interval counts
  AST_EFF_LOCAL: assert property (@(posedge sys_clk) disable iff (!rstn)
    !cd_r |-> eff_same_r == acc_same_r && eff_opp_r == acc_opp_r)
    else $error("saved accusations used outside diagnosis");
  // end forgets the saved copy and stops diagnosis
  AST_DROP: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_end && cd_r |=> sav_same_r == nds_pkg::RST_SAME && !cd_r)
    else $error("saved accusations kept after end");
  AST_DROP_OPP: assert property (@(posedge sys_clk) disable iff (!rstn)
    cd_end && cd_r |=> sav_opp_r == nds_pkg::RST_OPP)
    else $error("saved opposite accusations kept after end");
  // detect/init entry wipes convictions
  AST_ENTRY_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    clr_all |=> conv_same_r == nds_pkg::RST_SAME && conv_opp_r == nds_pkg::RST_OPP)
    else $error("convictions not cleared on entry");
  // detect/init entry wipes accusations, keeping same-cycle blame
  AST_ENTRY_ACC: assert property (@(posedge sys_clk) disable iff (!rstn)
    clr_all |=>
      ((acc_same_r & ~$past(blame_same)) == '0) && ((acc_opp_r & ~$past(blame_opp)) == '0))
    else $error("accusations not cleared on entry");
  // detect/init entry drops the saved copy, suspicions and diagnosis
  AST_ENTRY_SAV: assert property (@(posedge sys_clk) disable iff (!rstn)
    clr_all |=> sav_same_r == nds_pkg::RST_SAME && sav_opp_r == nds_pkg::RST_OPP &&
      !cd_r && susp_r == $past(susp_hit))
    else $error("diagnostic state kept on entry");
  // self-test gathers nothing about others
  AST_SELFTEST: assert property (@(posedge sys_clk) disable iff (!rstn)
    mode == nds_pkg::NDS_MODE_SELFTEST && !clr_all && !cd_end |=>
      ((acc_same_r & ~$past(acc_same_r)) == '0) && ((susp_r & ~$past(susp_r)) == '0))
    else $error("finding recorded in self-test");
  // idle and self-test never add an opposite accusation or suspicion
  AST_QUIET: assert property (@(posedge sys_clk) disable iff (!rstn)
    !gather |=> ((acc_opp_r & ~$past(acc_opp_r)) == '0) && ((susp_r & ~$past(susp_r)) == '0))
    else $error("finding recorded while not gathering");
  // blame always lands while gathering, even over a clear
  AST_BLAME: assert property (@(posedge sys_clk) disable iff (!rstn)
    gather |=> (($past(blame_same) & ~acc_same_r) == '0) &&
      (($past(blame_opp) & ~acc_opp_r) == '0))
    else $error("blame not recorded");
  // single unpinned error sets cell 0
  AST_SUSP_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
    gather && relay_err && !relay_pinned && relay_src == '0 && relay_mid == '0 |=> susp_r[0])
    else $error("suspicion cell not set");
  // row 1, column 2 lands in cell 5
  AST_SUSP_CELL: assert property (@(posedge sys_clk) disable iff (!rstn)
    gather && relay_err && !relay_pinned && relay_src == 3'h1 && relay_mid == 3'h2 |=> susp_r[5])
    else $error("suspicion cell for row 1 column 2 not set");
  // a pinned culprit raises no suspicion
  AST_PINNED: assert property (@(posedge sys_clk) disable iff (!rstn)
    relay_pinned |=> ((susp_r & ~$past(susp_r)) == '0))
    else $error("suspicion raised although pinned");
  // no relayed error, no new suspicion
  AST_SUSP_ONLY: assert property (@(posedge sys_clk) disable iff (!rstn)
    !relay_err |=> ((susp_r & ~$past(susp_r)) == '0))
    else $error("suspicion raised without relayed error");
  // a relayed error alone accuses nobody
  AST_NO_ACCUSE: assert property (@(posedge sys_clk) disable iff (!rstn)
    blame_same == '0 && blame_opp == '0 |=>
      ((acc_same_r & ~$past(acc_same_r)) == '0) && ((acc_opp_r & ~$past(acc_opp_r)) == '0))
    else $error("accusation raised without blame");
  // interval end restarts accusations and suspicions
  AST_INTERVAL: assert property (@(posedge sys_clk) disable iff (!rstn)
    interval_end && !clr_all && !(cd_start && gather) |=>
      ((acc_same_r & ~$past(blame_same)) == '0) && ((susp_r & ~$past(susp_hit)) == '0))
    else $error("interval end did not clear");
  // trust is neither accused nor convicted, both kinds
  AST_TRUST: assert property (@(posedge sys_clk) disable iff (!rstn)
    tr_same_r == ~(eff_same_r | conv_same_r))
    else $error("trust disagrees with accusation and conviction");
  AST_TRUST_OPP: assert property (@(posedge sys_clk) disable iff (!rstn)
    tr_opp_r == ~(eff_opp_r | conv_opp_r))
    else $error("opposite trust disagrees with accusation and conviction");

endmodule

// ==== tb/nds_cd_partner.sv ====
`timescale 1ns/10ps
// ------------------------------------------
// far side: collective diagnosis stand-in
// ------------------------------------------
module nds_cd_partner (
  // clock
  input  wire logic                       sys_clk,
  // accusations handed over at diagnosis start
  input  wire logic [nds_pkg::N_SAME-1:0] acc_same_submit,
  input  wire logic [nds_pkg::N_OPP-1:0]  acc_opp_submit,
  // agreed convictions returned
  output logic      [nds_pkg::N_SAME-1:0] conv_same_in,
  output logic      [nds_pkg::N_OPP-1:0]  conv_opp_in
);
  // single voter: convicts exactly what it was handed, one cycle later
  always_ff @(posedge sys_clk) begin
    conv_same_in <= acc_same_submit;
    conv_opp_in  <= acc_opp_submit;
  end
endmodule

// ==== tb/tb_node_diagnostic_state_manager.sv ====
`timescale 1ns/10ps
module tb_node_diagnostic_state_manager;
  // ------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  nds_pkg::nds_mode_t mode = nds_pkg::NDS_MODE_IDLE;
  logic mode_entry = 0, cd_start = 0, cd_end = 0, interval_end = 0;
  logic relay_err = 0, relay_pinned = 0;
  logic [2:0] relay_src = 0, relay_mid = 0, blame_opp = 0, co_in, ao_e, ao_s, c_o, t_o;
  logic [3:0] blame_same = 0, cs_in, as_e, as_s, c_s, t_s;
  logic [11:0] susp;
  logic cd_active;
  // ------------------------------------------
  // reference state, {same, opp} packed
  // ------------------------------------------
  logic [6:0] cur = 0, sav = 0, conv = 0, sub = 0, eff;
  logic [11:0] sp = 0;
  logic act = 0;
  logic [40:0] e;
  logic [40:0] exp_q[$];
  int mismatches = 0, num_checks = 0;
  int ml[6] = '{1, 2, 3, 4, 5, 0};
  always #50 sys_clk = ~sys_clk;
  nds_diag_state i_dut (.sys_clk(sys_clk), .rstn(rstn), .mode(mode), .mode_entry(mode_entry),
    .cd_start(cd_start), .cd_end(cd_end), .interval_end(interval_end),
    .conv_same_in(cs_in), .conv_opp_in(co_in), .blame_same(blame_same),
    .blame_opp(blame_opp), .relay_err(relay_err), .relay_src(relay_src),
    .relay_mid(relay_mid), .relay_pinned(relay_pinned), .acc_same_eff(as_e),
    .acc_opp_eff(ao_e), .acc_same_submit(as_s), .acc_opp_submit(ao_s), .conv_same(c_s),
    .conv_opp(c_o), .trust_same(t_s), .trust_opp(t_o), .susp(susp), .cd_active(cd_active));
  nds_cd_partner i_far (.sys_clk(sys_clk), .acc_same_submit(as_s), .acc_opp_submit(ao_s),
    .conv_same_in(cs_in), .conv_opp_in(co_in));
  // compare one field, count and report
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] ex);
    num_checks++;
    if (seen !== ex) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  // one cycle of stimulus with random blame/relay, plus predicted outputs
  task automatic step(input int m, input logic en, st, nd, ie);
    logic on;
    logic [6:0] bl;
    @(negedge sys_clk);
    bl = 7'(1 << $urandom_range(0, 9));
    mode = nds_pkg::nds_mode_t'(m);
    {mode_entry, cd_start, cd_end, interval_end} = {en, st, nd, ie};
    {blame_same, blame_opp} = bl;
    relay_err = 1'($urandom_range(0, 1));
    relay_pinned = ($urandom_range(0, 3) == 0);
    relay_src = 3'($urandom_range(0, 7));
    relay_mid = 3'($urandom_range(0, 7));
    on = !(m == 0 || m == 5);
    // detect/init entry wipes everything but the submitted copy
    if (en && (m == 3 || m == 4)) {cur, sav, conv, sp, act} = '0;
    if (st && on) begin
      {sub, sav, cur, sp} = {cur, cur, 7'h0, 12'h0};
    end else if (ie) {cur, sp} = '0;
    if (nd && act) {conv, sav} = {sub, 7'h0};
    act = (st && on) ? 1'b1 : (nd && act) ? 1'b0 : act;
    // blame and relayed-path suspicion, none in self-test or idle
    if (on) begin
      cur = cur | bl;
      if (relay_err && !relay_pinned && relay_src < 4 && relay_mid < 3)
        sp[relay_src*3+relay_mid] = 1'b1;
    end
    eff = cur | (act ? sav : 7'h0);
    exp_q.push_back({eff, sub, conv, ~(eff | conv), sp, act});
  endtask
  // ------------------------------------------
  // watcher: one note per clock edge
  // ------------------------------------------
  always @(posedge sys_clk) begin
    #1;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("eff", 12'({as_e, ao_e}), 12'(e[40:34]));
      check("submit", 12'({as_s, ao_s}), 12'(e[33:27]));
      check("conv", 12'({c_s, c_o}), 12'(e[26:20]));
      check("trust", 12'({t_s, t_o}), 12'(e[19:13]));
      check("susp", susp, e[12:1]);
      check("active", 12'(cd_active), 12'(e[0]));
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded run guard
  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
  // ------------------------------------------
  // main sequence: every mode, full diagnosis cycle
  // ------------------------------------------
  initial begin
    void'($urandom(6));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    foreach (ml[k]) begin
      step(ml[k], 1, 0, 0, 0);
      repeat (3) step(ml[k], 0, 0, 0, 0);
      step(ml[k], 0, 1, 0, 0);
      step(ml[k], 0, 0, 0, 0);
      step(ml[k], 0, 0, 0, 0);
      step(ml[k], 0, 0, 1, 0);
      step(ml[k], 0, 0, 0, 1);
      step(ml[k], 0, 0, 1, 0);
    end
    step(0, 0, 0, 0, 0);
    @(negedge sys_clk);
    print_verdict();
  end
endmodule
